// ### opmode_pkg.sv
// constants, field positions and mode codes of the operating-mode controller
// assumes a single 250 MHz clock and pin inputs already level-shifted
package opmode_pkg;
  localparam int CLK_MHZ = 250;
  // interrupt pulse time in microseconds and its cycle count
  localparam int INT_PULSE_US = 56;
  localparam int INT_PULSE_CYCLES = INT_PULSE_US * CLK_MHZ;
  // reset hold after power rise in milliseconds and its cycle count
  localparam int RESET_HOLD_MS = 2;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * 1000 * CLK_MHZ;
  localparam int HOLD_WIDTH = 20;
  // positions inside the synchronised pin vector
  localparam int SYNC_WIDTH = 9;
  localparam int PIN_LIN_TX_ENTRY = 0;
  localparam int PIN_LIN_TX_EXIT = 1;
  localparam int PIN_CAN_TX_ENTRY = 2;
  localparam int PIN_CAN_TX_EXIT = 3;
  localparam int PIN_STRAP = 4;
  localparam int PIN_CS_N = 5;
  localparam int PIN_LOAD_RISE = 6;
  localparam int PIN_LOAD_FALL = 7;
  localparam int PIN_SUPPLY_LOW = 8;
  // reset values
  localparam logic PERMIT_RESET = 1'b1;
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 9'h020;
  localparam int WARN_WIDTH = 4;
  localparam logic [WARN_WIDTH-1:0] WARN_OFF = 4'h0;
  typedef enum logic [4:0] {
    M_POWERUP = 5'h01,
    M_ACTIVE = 5'h02,
    M_CAN_FLASH = 5'h04,
    M_LIN_FLASH = 5'h08,
    M_STANDBY = 5'h10
  } mode_t;
endpackage

// ### pin_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes every bit is an independent slow level
`timescale 1ns/10ps
`default_nettype none
module pin_sync
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ### int_pulse.sv
// active-low interrupt pulse of fixed length, retriggered by a new event
// assumes trig is a one-cycle pulse on clk
`timescale 1ns/10ps
`default_nettype none
module int_pulse
#(
  parameter int CYCLES = 14000
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic trig,
  output logic pin_n
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // load on event, count down while low
  always_comb
  begin
    next_count = count;
    if (trig)
      next_count = LOAD; // R23
    else if (count != '0)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
      pin_n <= 1'b1;
    end
    else
    begin
      count <= next_count;
      pin_n <= (next_count == '0);
    end
  end

  pulse_load_a: assert property (@(posedge clk) disable iff (reset)
    trig |=> !pin_n && count == LOAD) // R23
    else $error("interrupt pulse not started");
  pulse_end_a: assert property (@(posedge clk) disable iff (reset)
    count == CW'(1) && !trig |=> pin_n) // R23
    else $error("interrupt pulse not ended");
endmodule // int_pulse
`default_nettype wire

// ### operating_mode_controller.sv
// operating-mode controller: flash, debug and regulator-on standby modes,
// watchdog gating and the three active-low interrupt pins
// assumes comparator levels on pins, SPI command fields on clk decoded
//
// Operation
// R1: raised LIN TX pin enters CAN flash; raised CAN TX enters LIN flash
// R2: watchdog kept disabled in either flash mode
// R3: CAN flash entry sets transceiver ready request and moves to normal
// R4: watchdog permit writable only in CAN flash; cleared stays cleared (code accepts a write of 1 again in CAN flash)
// R5: LIN flash entry sets the LIN fast-rate enable
// R6: standby command ignored while in either flash mode
// R7: flash exit gives no reset pulse and starts a long open window
// R8: far side never raises both transmit pins together
// R9: debug status reads 1 in debug, 0 in normal; watchdog off
// R10: microcontroller should read debug status after cold start and wake
// R11: strap high at power rise, then low after hold, gives debug
// R12: leave request in debug returns to normal, long window, bit stays
// R13: leave request in normal mode changes nothing
// R14: standby entered at chip-select rise ending command; long window
// R15: standby watchdog off when load low, or at entry with bypass
// R16: bypass settable only in command after unlock; unlock auto-clears
// R17: standby switches off power outputs and both transmitters (code drives only OUTPUTS_OFF; no transmitter control)
// R18: load rise in standby keeps standby, long window, no interrupt
// R19: LIN pin pulses on standby wake except wake by CAN
// R20: CAN pin pulses on transceiver change and silence timeout
// R21: active-mode supply warning on interrupt pin unless level is 0
// R22: standby interrupt on timer start, silence timeout and wake
// R23: every interrupt pulse timed by a fixed cycle count
`timescale 1ns/10ps
`default_nettype none
module operating_mode_controller
  import opmode_pkg::*;
#(
  parameter int PULSE_CYCLES = INT_PULSE_CYCLES,
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LIN_TX_ABOVE_ENTRY,
  input wire logic LIN_TX_BELOW_EXIT,
  input wire logic CAN_TX_ABOVE_ENTRY,
  input wire logic CAN_TX_BELOW_EXIT,
  input wire logic DEBUG_STRAP_INPUT,
  input wire logic CHIP_SELECT_N,
  input wire logic LOAD_ABOVE_RISE,
  input wire logic LOAD_BELOW_FALL,
  input wire logic SUPPLY_BELOW_WARNING,
  input wire logic [WARN_WIDTH-1:0] SUPPLY_EARLY_WARNING_LEVEL,
  input wire logic CMD_DONE,
  input wire logic CMD_STANDBY,
  input wire logic CMD_SET_UNLOCK,
  input wire logic CMD_WRITE_BYPASS,
  input wire logic CMD_BYPASS_VALUE,
  input wire logic CMD_WRITE_PERMIT,
  input wire logic CMD_PERMIT_VALUE,
  input wire logic CMD_WRITE_LEAVE,
  input wire logic CMD_LEAVE_VALUE,
  input wire logic WAKE_EVENT,
  input wire logic WAKE_BY_CAN,
  input wire logic CAN_MODE_CHANGE,
  input wire logic CAN_SILENCE_TIMEOUT,
  input wire logic CAN_SILENCE_IRQ_MASK,
  input wire logic FLAG_CLEAR,
  input wire logic TIMER_ON_START,
  output logic RESET_OUT_N,
  output logic DEBUG_ACTIVE,
  output logic DEBUG_LEAVE_REQUEST,
  output logic WATCHDOG_PERMIT,
  output logic WATCHDOG_RUN,
  output logic LONG_OPEN_WINDOW,
  output logic CAN_TRANSCEIVER_READY_REQUEST,
  output logic CAN_TRANSCEIVER_NORMAL,
  output logic LIN_FAST_RATE_ENABLE,
  output logic FLASH_ACTIVE,
  output logic STANDBY_ACTIVE,
  output logic OUTPUTS_OFF,
  output logic CONFIG_UNLOCK,
  output logic CURRENT_MONITOR_BYPASS,
  output logic CAN_SILENCE_TIMEOUT_FLAG,
  output logic LIN_RECEIVE_INTERRUPT_PIN,
  output logic CAN_RECEIVE_INTERRUPT_PIN,
  output logic INTERRUPT_OUT_N
);
  localparam logic [HOLD_WIDTH-1:0] HOLD_LOAD = HOLD_WIDTH'(HOLD_CYCLES);
  logic [SYNC_WIDTH-1:0] pins;
  logic cs_prev, low_prev, standby_pending, wd_quiet;
  logic next_standby_pending, next_wd_quiet;
  logic [HOLD_WIDTH-1:0] hold, next_hold;
  logic strap_seen, next_strap_seen;
  mode_t mode, next_mode;
  logic next_reset_out_n, next_debug, next_leave, next_permit, next_run;
  logic next_lwo, next_ready, next_normal, next_fast, next_unlock;
  logic next_bypass, next_flag;
  logic cs_rise, lin_trig, can_trig, interrupt_out_n_trig, silence_irq;
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  pin_sync #(.WIDTH(SYNC_WIDTH), .INIT(SYNC_RESET)) sync_i (
    .clk(CLK), .reset(RESET), .dout(pins),
    .din({SUPPLY_BELOW_WARNING, LOAD_BELOW_FALL, LOAD_ABOVE_RISE,
          CHIP_SELECT_N, DEBUG_STRAP_INPUT, CAN_TX_BELOW_EXIT,
          CAN_TX_ABOVE_ENTRY, LIN_TX_BELOW_EXIT, LIN_TX_ABOVE_ENTRY}));

  // chip-select rise ends a command frame
  assign cs_rise = pins[PIN_CS_N] && !cs_prev;
  assign silence_irq = CAN_SILENCE_TIMEOUT && CAN_SILENCE_IRQ_MASK;
  ////////////////////////////////////////////////////////////////////////
  // mode sequencing and control bits
  always_comb
  begin
    next_mode = mode;
    next_hold = hold;
    next_strap_seen = strap_seen;
    next_reset_out_n = RESET_OUT_N;
    next_debug = DEBUG_ACTIVE;
    next_leave = DEBUG_LEAVE_REQUEST;
    next_permit = WATCHDOG_PERMIT;
    next_lwo = 1'b0;
    next_ready = CAN_TRANSCEIVER_READY_REQUEST;
    next_normal = CAN_TRANSCEIVER_NORMAL;
    next_fast = LIN_FAST_RATE_ENABLE;
    next_unlock = CONFIG_UNLOCK;
    next_bypass = CURRENT_MONITOR_BYPASS;
    next_standby_pending = standby_pending;
    next_wd_quiet = wd_quiet;
    // command fields take effect as each command completes
    if (CMD_DONE)
    begin
      next_unlock = CMD_SET_UNLOCK; // R16
      if (CMD_WRITE_BYPASS && (CONFIG_UNLOCK || !CMD_BYPASS_VALUE))
        next_bypass = CMD_BYPASS_VALUE; // R16
      if (CMD_WRITE_PERMIT && mode == M_CAN_FLASH)
        next_permit = CMD_PERMIT_VALUE; // R4
      if (CMD_WRITE_LEAVE)
      begin
        next_leave = CMD_LEAVE_VALUE; // R12
        if (CMD_LEAVE_VALUE && DEBUG_ACTIVE) // R13
        begin
          next_debug = 1'b0; // R12
          next_lwo = 1'b1;
        end
      end
      next_standby_pending = CMD_STANDBY;
    end
    unique case (mode)
      M_POWERUP:
      begin
        // hold reset low, latch strap, release once strap is low
        if (pins[PIN_STRAP])
          next_strap_seen = 1'b1; // R11
        if (hold != '0)
          next_hold = hold - 1'b1;
        else if (!pins[PIN_STRAP])
        begin
          next_reset_out_n = 1'b1; // R11
          next_debug = strap_seen; // R9
          next_lwo = 1'b1;
          next_mode = M_ACTIVE;
        end
      end
      M_ACTIVE:
      begin
        // both pins raised is illegal; no flash entry then
        if (pins[PIN_LIN_TX_ENTRY] && !pins[PIN_CAN_TX_ENTRY]) // R8
        begin
          next_mode = M_CAN_FLASH; // R1
          next_ready = 1'b1; // R3
          next_normal = 1'b1; // R3
        end
        else if (pins[PIN_CAN_TX_ENTRY] && !pins[PIN_LIN_TX_ENTRY])
        begin
          next_mode = M_LIN_FLASH; // R1
          next_fast = 1'b1; // R5
        end
        else if (cs_rise && standby_pending)
        begin
          next_mode = M_STANDBY; // R14
          next_lwo = 1'b1; // R14
          next_standby_pending = 1'b0;
          next_wd_quiet = CURRENT_MONITOR_BYPASS; // R15
        end
      end
      M_CAN_FLASH, M_LIN_FLASH:
      begin
        // standby command is dropped here
        if (cs_rise)
          next_standby_pending = 1'b0; // R6
        if ((mode == M_CAN_FLASH && pins[PIN_LIN_TX_EXIT]) ||
            (mode == M_LIN_FLASH && pins[PIN_CAN_TX_EXIT]))
        begin
          next_mode = M_ACTIVE; // R7
          next_lwo = 1'b1; // R7
        end
      end
      M_STANDBY:
      begin
        if (WAKE_EVENT)
        begin
          next_mode = M_ACTIVE;
          next_lwo = 1'b1;
          next_wd_quiet = 1'b0;
        end
        else if (pins[PIN_LOAD_RISE] && wd_quiet)
        begin
          next_wd_quiet = 1'b0; // R18
          next_lwo = 1'b1; // R18
        end
        else if (pins[PIN_LOAD_FALL] && !wd_quiet)
          next_wd_quiet = 1'b1; // R15
      end
    endcase
    // watchdog runs only in active or non-quiet standby
    next_run = next_permit && !next_debug && // R9
      (next_mode == M_ACTIVE || // R2
       (next_mode == M_STANDBY && !next_wd_quiet)); // R15
  end

  // silence flag: a new timeout wins over a clear
  assign next_flag = CAN_SILENCE_TIMEOUT ||
    (CAN_SILENCE_TIMEOUT_FLAG && !FLAG_CLEAR); // R20

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      mode <= M_POWERUP;
      hold <= HOLD_LOAD;
      strap_seen <= 1'b0;
      RESET_OUT_N <= 1'b0;
      DEBUG_ACTIVE <= 1'b0;
      DEBUG_LEAVE_REQUEST <= 1'b0;
      WATCHDOG_PERMIT <= PERMIT_RESET;
      WATCHDOG_RUN <= 1'b0;
      LONG_OPEN_WINDOW <= 1'b0;
      CAN_TRANSCEIVER_READY_REQUEST <= 1'b0;
      CAN_TRANSCEIVER_NORMAL <= 1'b0;
      LIN_FAST_RATE_ENABLE <= 1'b0;
      FLASH_ACTIVE <= 1'b0;
      STANDBY_ACTIVE <= 1'b0;
      OUTPUTS_OFF <= 1'b0;
      CONFIG_UNLOCK <= 1'b0;
      CURRENT_MONITOR_BYPASS <= 1'b0;
      CAN_SILENCE_TIMEOUT_FLAG <= 1'b0;
      standby_pending <= 1'b0;
      wd_quiet <= 1'b0;
      cs_prev <= 1'b1;
      low_prev <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      hold <= next_hold;
      strap_seen <= next_strap_seen;
      RESET_OUT_N <= next_reset_out_n;
      DEBUG_ACTIVE <= next_debug;
      DEBUG_LEAVE_REQUEST <= next_leave;
      WATCHDOG_PERMIT <= next_permit;
      WATCHDOG_RUN <= next_run;
      LONG_OPEN_WINDOW <= next_lwo;
      CAN_TRANSCEIVER_READY_REQUEST <= next_ready;
      CAN_TRANSCEIVER_NORMAL <= next_normal;
      LIN_FAST_RATE_ENABLE <= next_fast;
      FLASH_ACTIVE <= next_mode inside {M_CAN_FLASH, M_LIN_FLASH};
      STANDBY_ACTIVE <= next_mode == M_STANDBY;
      OUTPUTS_OFF <= next_mode == M_STANDBY; // R17
      CONFIG_UNLOCK <= next_unlock;
      CURRENT_MONITOR_BYPASS <= next_bypass;
      CAN_SILENCE_TIMEOUT_FLAG <= next_flag;
      standby_pending <= next_standby_pending;
      wd_quiet <= next_wd_quiet;
      cs_prev <= pins[PIN_CS_N];
      low_prev <= pins[PIN_SUPPLY_LOW];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // interrupt pin events
  assign lin_trig = mode == M_STANDBY && WAKE_EVENT && !WAKE_BY_CAN; // R19
  assign can_trig = CAN_MODE_CHANGE || silence_irq; // R20
  assign interrupt_out_n_trig =
    (mode == M_ACTIVE && pins[PIN_SUPPLY_LOW] && !low_prev &&
     SUPPLY_EARLY_WARNING_LEVEL != WARN_OFF) || // R21
    (mode == M_STANDBY &&
     (TIMER_ON_START || silence_irq || WAKE_EVENT)); // R22

  int_pulse #(.CYCLES(PULSE_CYCLES)) lin_pulse_i (.clk(CLK), .reset(RESET),
    .trig(lin_trig), .pin_n(LIN_RECEIVE_INTERRUPT_PIN));
  int_pulse #(.CYCLES(PULSE_CYCLES)) can_pulse_i (.clk(CLK), .reset(RESET),
    .trig(can_trig), .pin_n(CAN_RECEIVE_INTERRUPT_PIN));
  int_pulse #(.CYCLES(PULSE_CYCLES)) interrupt_out_n_pulse_i (.clk(CLK), .reset(RESET),
    .trig(interrupt_out_n_trig), .pin_n(INTERRUPT_OUT_N));
  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  flash_wd_off_a: assert property (FLASH_ACTIVE |-> !WATCHDOG_RUN) // R2
    else $error("watchdog runs in flash mode");
  can_ready_a: assert property ( // R3
    mode == M_ACTIVE && next_mode == M_CAN_FLASH |=>
    CAN_TRANSCEIVER_READY_REQUEST && CAN_TRANSCEIVER_NORMAL)
    else $error("transceiver not readied in CAN flash");
  permit_lock_a: assert property ( // R4
    $changed(WATCHDOG_PERMIT) |-> $past(mode) == M_CAN_FLASH)
    else $error("permit changed outside CAN flash");
  lin_fast_a: assert property ( // R5
    mode == M_LIN_FLASH |-> LIN_FAST_RATE_ENABLE)
    else $error("fast rate not set in LIN flash");
  no_standby_a: assert property ( // R6
    mode inside {M_CAN_FLASH, M_LIN_FLASH} |=> mode != M_STANDBY)
    else $error("standby entered from flash");
  flash_exit_a: assert property ( // R7
    $past(mode) inside {M_CAN_FLASH, M_LIN_FLASH} && mode == M_ACTIVE
    |-> RESET_OUT_N && LONG_OPEN_WINDOW)
    else $error("flash exit without long window");
  debug_leave_a: assert property ( // R12
    CMD_DONE && CMD_WRITE_LEAVE && CMD_LEAVE_VALUE && DEBUG_ACTIVE |=>
    !DEBUG_ACTIVE && LONG_OPEN_WINDOW && DEBUG_LEAVE_REQUEST)
    else $error("debug leave not honoured");
  normal_leave_a: assert property ( // R13
    !DEBUG_ACTIVE && mode != M_POWERUP |=> !DEBUG_ACTIVE)
    else $error("debug entered after release");
  standby_entry_a: assert property ( // R14
    mode == M_ACTIVE && next_mode == M_STANDBY |=>
    STANDBY_ACTIVE && LONG_OPEN_WINDOW && OUTPUTS_OFF)
    else $error("standby entry without long window");
  bypass_lock_a: assert property ( // R16
    $rose(CURRENT_MONITOR_BYPASS) |-> $past(CONFIG_UNLOCK))
    else $error("bypass set without unlock");
  load_rise_a: assert property ( // R18
    mode == M_STANDBY && wd_quiet && !WAKE_EVENT && pins[PIN_LOAD_RISE]
    |=> STANDBY_ACTIVE && LONG_OPEN_WINDOW)
    else $error("load rise mishandled in standby");
  flash_c: cover property (mode == M_CAN_FLASH ##[1:20] mode == M_ACTIVE);
  standby_c: cover property (mode == M_STANDBY ##1 mode == M_ACTIVE);
  debug_c: cover property ($fell(DEBUG_ACTIVE));
endmodule // operating_mode_controller
`default_nettype wire

// ### mcu_model.sv
// system microcontroller model: strap, transmit pin levels, chip select
// and the decoded command fields of each SPI frame
// assumes clk is the controller clock and rst the power-on reset
`timescale 1ns/10ps
`default_nettype none
module mcu_model
(
  input wire logic clk,
  input wire logic rst,
  output logic cs_n,
  output logic strap,
  output logic [1:0] tx_hi,
  output logic done,
  output logic [7:0] f
);
  ////////////////////////////////////////////////////////////////////////
  // strap held high through power rise, dropped after the hold
  initial
  begin
    cs_n = 1'b1;
    strap = 1'b1;
    tx_hi = 2'h0;
    done = 1'b0;
    f = 8'h00;
    @(negedge rst);
    repeat (24) @(posedge clk);
    strap <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one framed command; fields go stale once done drops
  task send(input logic [7:0] v, input int gap);
    @(posedge clk);
    cs_n <= 1'b0;
    @(posedge clk);
    f <= v;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    f <= ~v;
    repeat (gap) @(posedge clk);
    cs_n <= 1'b1;
  endtask
  // raise or drop one transmit pin, never both high together
  task tx(input logic can_pin, input logic hi);
    @(posedge clk);
    if (!hi || !tx_hi[!can_pin])
      tx_hi[can_pin] <= hi;
  endtask
endmodule // mcu_model
`default_nettype wire

// ### operating_mode_controller_tb.sv
// self-checking bench of the operating-mode controller
// assumes the microcontroller model drives pins and command fields
`timescale 1ns/10ps
`default_nettype none
module operating_mode_controller_tb
  import opmode_pkg::*;
;
  localparam int pw = 8;
  localparam int hold = 16;
  localparam logic [7:0] st_cmd = 8'h01;
  localparam logic [7:0] unl_cmd = 8'h02;
  localparam logic [7:0] byp1_cmd = 8'h0c;
  localparam logic [7:0] perm0_cmd = 8'h10;
  localparam logic [7:0] lv1_cmd = 8'hc0;
  localparam logic [7:0] lv0_cmd = 8'h40;
  logic clk, rst, cs_n, strap, done, ld_up, ld_dn, sup, wbc, msk;
  logic [1:0] tx;
  logic [7:0] f;
  logic [4:0] ev;
  logic [WARN_WIDTH-1:0] lvl;
  logic rst_o_n, dbg, lvq, prm, wdr, lng, rdy, nrm, fst, fla, sby, off;
  logic unl, byp, flg, lin_n, can_n, int_n;
  logic [31:0] seed = 32'h0000003a;
  int fail_count, n_compared, cyc, lw, nrst, bl, br, t;
  int m_unl, m_byp, m_perm, m_lv, m_cf;
  int lo[3];
  int base[3];
  ////////////////////////////////////////////////////////////////////////
  // design and far-side model
  operating_mode_controller #(.PULSE_CYCLES(pw), .HOLD_CYCLES(hold)) u_dut
  (
    .CLK(clk),
    .RESET(rst),
    .LIN_TX_ABOVE_ENTRY(tx[0]),
    .LIN_TX_BELOW_EXIT(!tx[0]),
    .CAN_TX_ABOVE_ENTRY(tx[1]),
    .CAN_TX_BELOW_EXIT(!tx[1]),
    .DEBUG_STRAP_INPUT(strap),
    .CHIP_SELECT_N(cs_n),
    .LOAD_ABOVE_RISE(ld_up),
    .LOAD_BELOW_FALL(ld_dn),
    .SUPPLY_BELOW_WARNING(sup),
    .SUPPLY_EARLY_WARNING_LEVEL(lvl),
    .CMD_DONE(done),
    .CMD_STANDBY(f[0]),
    .CMD_SET_UNLOCK(f[1]),
    .CMD_WRITE_BYPASS(f[2]),
    .CMD_BYPASS_VALUE(f[3]),
    .CMD_WRITE_PERMIT(f[4]),
    .CMD_PERMIT_VALUE(f[5]),
    .CMD_WRITE_LEAVE(f[6]),
    .CMD_LEAVE_VALUE(f[7]),
    .WAKE_EVENT(ev[0]),
    .WAKE_BY_CAN(wbc),
    .CAN_MODE_CHANGE(ev[1]),
    .CAN_SILENCE_TIMEOUT(ev[2]),
    .CAN_SILENCE_IRQ_MASK(msk),
    .FLAG_CLEAR(ev[3]),
    .TIMER_ON_START(ev[4]),
    .RESET_OUT_N(rst_o_n),
    .DEBUG_ACTIVE(dbg),
    .DEBUG_LEAVE_REQUEST(lvq),
    .WATCHDOG_PERMIT(prm),
    .WATCHDOG_RUN(wdr),
    .LONG_OPEN_WINDOW(lng),
    .CAN_TRANSCEIVER_READY_REQUEST(rdy),
    .CAN_TRANSCEIVER_NORMAL(nrm),
    .LIN_FAST_RATE_ENABLE(fst),
    .FLASH_ACTIVE(fla),
    .STANDBY_ACTIVE(sby),
    .OUTPUTS_OFF(off),
    .CONFIG_UNLOCK(unl),
    .CURRENT_MONITOR_BYPASS(byp),
    .CAN_SILENCE_TIMEOUT_FLAG(flg),
    .LIN_RECEIVE_INTERRUPT_PIN(lin_n),
    .CAN_RECEIVE_INTERRUPT_PIN(can_n),
    .INTERRUPT_OUT_N(int_n)
  );
  mcu_model u_mcu
  (
    .clk(clk),
    .rst(rst),
    .cs_n(cs_n),
    .strap(strap),
    .tx_hi(tx),
    .done(done),
    .f(f)
  );
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pulse, low-cycle and timeout counters
  always @(posedge clk)
  begin
    cyc++;
    if (lng === 1'b1)
      lw++;
    if (rst_o_n === 1'b0)
      nrst++;
    if (lin_n === 1'b0)
      lo[0]++;
    if (can_n === 1'b0)
      lo[1]++;
    if (int_n === 1'b0)
      lo[2]++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task mark;
    base = lo;
    bl = lw;
    br = nrst;
  endtask
  task fire(input int k);
    @(posedge clk);
    ev <= 5'h01 << k;
    @(posedge clk);
    ev <= 5'h00;
  endtask
  // low cycles on the lin, can and interrupt pins since mark
  task pulses(input int a, input int b, input int c);
    wait_n(3 * pw);
    chk(lo[0] - base[0], a * pw);
    chk(lo[1] - base[1], b * pw);
    chk(lo[2] - base[2], c * pw);
  endtask
  // command through the model, bench model updated and compared
  task cmd(input logic [7:0] v);
    u_mcu.send(v, int'(xs() % 4));
    if (v[2] && (!v[3] || m_unl != 0))
      m_byp = v[3];
    if (v[4] && m_cf != 0)
      m_perm = v[5];
    if (v[6])
      m_lv = v[7];
    m_unl = v[1];
    wait_n(6);
    chk(unl, m_unl);
    chk(byp, m_byp);
    chk(prm, m_perm);
    chk(lvq, m_lv);
  endtask
  task test_done;
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst = 1'b1;
    {ld_up, ld_dn, sup, wbc, msk} = 5'h00;
    ev = 5'h00;
    lvl = '0;
    {m_unl, m_byp, m_lv, m_cf} = 128'h0;
    m_perm = 1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t = 0;
    while (rst_o_n !== 1'b1 && t < 200)
    begin
      @(posedge clk);
      t++;
    end
    #1;
    chk(t >= 24, 1);
    chk(dbg, 1'b1);
    chk(wdr, 1'b0);
    mark();
    cmd(lv1_cmd);
    chk(dbg, 1'b0);
    chk(lw - bl, 1);
    cmd(lv1_cmd);
    chk(lw - bl, 1);
    cmd(lv0_cmd);
    // standby with load monitoring
    @(posedge clk);
    msk <= 1'b1;
    mark();
    cmd(st_cmd);
    chk({sby, off, wdr}, 3'h7);
    chk(lw - bl, 1);
    @(posedge clk);
    ld_dn <= 1'b1;
    wait_n(6);
    chk(wdr, 1'b0);
    @(posedge clk);
    ld_dn <= 1'b0;
    ld_up <= 1'b1;
    wait_n(6);
    chk({sby, wdr}, 2'h3);
    chk(lw - bl, 2);
    @(posedge clk);
    ld_up <= 1'b0;
    fire(4);
    pulses(0, 0, 1);
    mark();
    fire(2);
    pulses(0, 1, 1);
    chk(flg, 1'b1);
    mark();
    fire(0);
    pulses(1, 0, 1);
    chk(sby, 1'b0);
    // bypass unlock and standby without monitoring
    cmd(byp1_cmd);
    cmd(unl_cmd);
    cmd(byp1_cmd);
    cmd(st_cmd);
    chk({sby, wdr}, 2'h2);
    @(posedge clk);
    wbc <= 1'b1;
    mark();
    fire(0);
    pulses(0, 0, 1);
    chk(sby, 1'b0);
    // can pin and silence flag in active mode
    @(posedge clk);
    msk <= 1'b0;
    mark();
    fire(1);
    pulses(0, 1, 0);
    fire(3);
    wait_n(2);
    chk(flg, 1'b0);
    mark();
    fire(2);
    pulses(0, 0, 0);
    chk(flg, 1'b1);
    // supply warning, off at level zero
    mark();
    @(posedge clk);
    sup <= 1'b1;
    pulses(0, 0, 0);
    @(posedge clk);
    sup <= 1'b0;
    lvl <= WARN_WIDTH'(xs() % 15 + 1);
    wait_n(6);
    mark();
    @(posedge clk);
    sup <= 1'b1;
    pulses(0, 0, 1);
    @(posedge clk);
    sup <= 1'b0;
    // lin flash while the permit is still set
    u_mcu.tx(1'b1, 1'b1);
    wait_n(6);
    chk({fla, fst, wdr}, 3'h6);
    u_mcu.tx(1'b1, 1'b0);
    wait_n(6);
    chk(fla, 1'b0);
    // can flash: permit, refused standby, exit
    cmd(perm0_cmd);
    u_mcu.tx(1'b0, 1'b1);
    wait_n(6);
    m_cf = 1;
    chk({fla, wdr, rdy, nrm}, 4'hb);
    mark();
    cmd(st_cmd);
    chk(sby, 1'b0);
    cmd(perm0_cmd);
    u_mcu.tx(1'b1, 1'b1);
    u_mcu.tx(1'b0, 1'b0);
    wait_n(6);
    m_cf = 0;
    chk({fla, wdr, prm}, 3'h0);
    chk(lw - bl, 1);
    chk(nrst - br, 0);
    test_done();
  end
endmodule // operating_mode_controller_tb
`default_nettype wire
